/* File: hdl/trs_pkg.sv */
// Purpose: Shared constants and types for the tariff register selector.
// Assumes: Codes are held as packed BCD digits, limits as 16-bit raw values.
// Notes: Register offsets are word indices on the plain register port.
package trs_pkg;

    // Register word indices.
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_LIMIT_2 = 4'h1;
    localparam logic [3:0] REG_LIMIT_3 = 4'h2;
    localparam logic [3:0] REG_LIMIT_4 = 4'h3;
    localparam logic [3:0] REG_HC_THRESH = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_CONTROL = 4'h6;
    localparam logic [3:0] REG_MAIN_ENERGY = 4'h7;
    localparam logic [3:0] REG_TOTAL_VOL = 4'h8;
    localparam logic [3:0] REG_TARIFF_2 = 4'h9;
    localparam logic [3:0] REG_TARIFF_3 = 4'ha;
    localparam logic [3:0] REG_TARIFF_4 = 4'hb;

    // Tariff type codes as BCD.
    localparam logic [7:0] TT_NONE = 8'h00;
    localparam logic [7:0] TT_FLOW = 8'h12;
    localparam logic [7:0] TT_DELTA = 8'h13;
    localparam logic [7:0] TT_INLET = 8'h14;
    localparam logic [7:0] TT_OUTLET = 8'h15;
    localparam logic [7:0] TT_TIME = 8'h19;
    localparam logic [7:0] TT_VOLUME = 8'h20;
    localparam logic [7:0] TT_PQ = 8'h21;

    // Combined heat/cooling meter types and the auto-detect code digit.
    localparam logic [3:0] METER_HC_A = 4'h3;
    localparam logic [3:0] METER_HC_B = 4'h6;
    localparam logic [3:0] AUTO_DETECT_DIGIT = 4'h8;

    // Limit resolution factors per nominal-flow class.
    localparam logic [9:0] RES_FACTOR_0 = 10'h001;
    localparam logic [9:0] RES_FACTOR_1 = 10'h00a;
    localparam logic [9:0] RES_FACTOR_2 = 10'h064;
    localparam logic [9:0] RES_FACTOR_3 = 10'h3e8;

    // Values after reset.
    localparam logic [31:0] RESET_CONFIG = 32'h0000_0000;
    localparam logic [15:0] RESET_LIMIT = 16'h0000;
    localparam logic [31:0] RESET_ACC = 32'h0000_0000;

    // Band codes out of the limit classifier.
    localparam logic [1:0] BAND_MAIN = 2'h0;
    localparam logic [1:0] BAND_T2 = 2'h1;
    localparam logic [1:0] BAND_T3 = 2'h2;
    localparam logic [1:0] BAND_T4 = 2'h3;

    // Live measurements from the meter's measurement path.
    typedef struct packed {
        logic [15:0] flow;
        logic [15:0] power;
        logic signed [15:0] inlet_temp;
        logic signed [15:0] outlet_temp;
        logic [10:0] time_min;
    } trs_meas_type;

    // Stored configuration word.
    typedef struct packed {
        logic [7:0] unused;
        logic [11:0] flow_sensor_code;
        logic [3:0] meter_type;
        logic [7:0] tariff_type_code;
    } trs_config_type;

endpackage

/* File: hdl/trs_limit_scaler.sv */
// Purpose: Brings a raw tariff limit to the resolution of the measured value.
// Assumes: Flow-unit limits are unsigned, temperature and time limits signed.
// Notes: Purely combinational; the stored raw value is never altered.
`timescale 1ns/1ps
`default_nettype none
module trs_limit_scaler (
    input wire logic [15:0] raw,
    input wire logic [1:0] res_class,
    input wire logic flow_units,
    output logic signed [31:0] scaled
);

    // Factor lookup by nominal-flow class.
    wire logic [9:0] factor;
    wire logic [31:0] product;
    assign factor = (res_class == 2'h0) ? trs_pkg::RES_FACTOR_0 :
                    (res_class == 2'h1) ? trs_pkg::RES_FACTOR_1 :
                    (res_class == 2'h2) ? trs_pkg::RES_FACTOR_2 :
                                          trs_pkg::RES_FACTOR_3;
    assign product = {16'h0000, raw} * {22'h000000, factor};

    // Temperatures and clock times keep their plain signed value.
    assign scaled = flow_units ? product : {{16{raw[15]}}, raw};

endmodule // trs_limit_scaler
`default_nettype wire

/* File: hdl/trs_band_classify.sv */
// Purpose: Sorts a measured value into one of four bands against three limits.
// Assumes: Limits are ordered by the configuring party.
// Notes: Descending mode serves the temperature-difference tariff.
`timescale 1ns/1ps
`default_nettype none
module trs_band_classify (
    input wire logic signed [31:0] value,
    input wire logic signed [31:0] lim_2,
    input wire logic signed [31:0] lim_3,
    input wire logic signed [31:0] lim_4,
    input wire logic descending,
    output logic [1:0] band
);

    // Ascending bands are open below and closed above each limit.
    wire logic [1:0] band_up;
    wire logic [1:0] band_down;
    assign band_up = (value > lim_4) ? trs_pkg::BAND_T4 :
                     (value > lim_3) ? trs_pkg::BAND_T3 :
                     (value > lim_2) ? trs_pkg::BAND_T2 : trs_pkg::BAND_MAIN;

    // Descending bands are closed below and open above each limit.
    assign band_down = (value < lim_4) ? trs_pkg::BAND_T4 :
                       (value < lim_3) ? trs_pkg::BAND_T3 :
                       (value < lim_2) ? trs_pkg::BAND_T2 : trs_pkg::BAND_MAIN;

    assign band = descending ? band_down : band_up;

endmodule // trs_band_classify
`default_nettype wire

/* File: hdl/trs_tariff_selector.sv */
// Purpose: Steers each accumulation update into the main and tariff accumulators.
// Assumes: Measurements and update strobe come from logic on the same clock.
// Notes: The tariff condition is sampled on the update strobe cycle.
`timescale 1ns/1ps
`default_nettype none
module trs_tariff_selector (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic acc_update,
    input wire logic [15:0] energy_inc,
    input wire logic [15:0] volume_inc,
    input wire trs_pkg::trs_meas_type meas,
    input wire logic auto_detect_valid,
    input wire logic [11:0] auto_detect_code,
    output logic upd_strobe,
    output logic [2:0] tariff_hit,
    output logic [15:0] tariff_inc
);

    trs_pkg::trs_config_type config_q;
    logic [15:0] limit_2_q;
    logic [15:0] limit_3_q;
    logic [15:0] limit_4_q;
    logic [15:0] hc_thresh_q;
    logic [31:0] main_energy_q;
    logic [31:0] total_vol_q;
    logic [31:0] tariff_acc_2_q;
    logic [31:0] tariff_acc_3_q;
    logic [31:0] tariff_acc_4_q;
    logic [31:0] rdata_q;
    logic upd_q;
    logic [2:0] hit_q;
    logic [15:0] inc_q;
    logic [15:0] energy_q;
    logic [15:0] volume_q;
    logic [1:0] band_q;
    logic clear_q;

    // Register decode.
    wire logic wr_config;
    wire logic wr_lim2;
    wire logic wr_lim3;
    wire logic wr_lim4;
    wire logic wr_hc;
    wire logic wr_clear;
    assign wr_config = reg_wr && (reg_addr == trs_pkg::REG_CONFIG);
    assign wr_lim2 = reg_wr && (reg_addr == trs_pkg::REG_LIMIT_2);
    assign wr_lim3 = reg_wr && (reg_addr == trs_pkg::REG_LIMIT_3);
    assign wr_lim4 = reg_wr && (reg_addr == trs_pkg::REG_LIMIT_4);
    assign wr_hc = reg_wr && (reg_addr == trs_pkg::REG_HC_THRESH);
    assign wr_clear = reg_wr && (reg_addr == trs_pkg::REG_CONTROL) && reg_wdata[0];

    // Tariff type decode.
    wire logic [7:0] tcode;
    wire logic is_flow;
    wire logic is_delta;
    wire logic is_inlet;
    wire logic is_outlet;
    wire logic is_time;
    wire logic is_volume;
    wire logic is_pq;
    wire logic is_banded;
    wire logic hc_meter;
    assign tcode = config_q.tariff_type_code;
    assign is_flow = (tcode == trs_pkg::TT_FLOW);
    assign is_delta = (tcode == trs_pkg::TT_DELTA);
    assign is_inlet = (tcode == trs_pkg::TT_INLET);
    assign is_outlet = (tcode == trs_pkg::TT_OUTLET);
    assign is_time = (tcode == trs_pkg::TT_TIME);
    assign is_volume = (tcode == trs_pkg::TT_VOLUME);
    assign is_pq = (tcode == trs_pkg::TT_PQ);
    assign is_banded = is_flow || is_delta || is_inlet || is_outlet;
    assign hc_meter = (config_q.meter_type == trs_pkg::METER_HC_A) ||
                      (config_q.meter_type == trs_pkg::METER_HC_B);

    // Flow-unit limits take the resolution of the nominal flow class.
    wire logic flow_units;
    wire logic [1:0] res_class;
    assign flow_units = is_flow || is_pq;
    assign res_class = config_q.flow_sensor_code[5:4];

    wire logic signed [31:0] lim_2;
    wire logic signed [31:0] lim_3;
    wire logic signed [31:0] lim_4;

    trs_limit_scaler u_scale_2 (
        .raw(limit_2_q),
        .res_class(res_class),
        .flow_units(flow_units),
        .scaled(lim_2)
    );

    trs_limit_scaler u_scale_3 (
        .raw(limit_3_q),
        .res_class(res_class),
        .flow_units(flow_units),
        .scaled(lim_3)
    );

    trs_limit_scaler u_scale_4 (
        .raw(limit_4_q),
        .res_class(res_class),
        .flow_units(flow_units),
        .scaled(lim_4)
    );

    // Measured quantities widened to the comparison width.
    wire logic signed [31:0] flow_w;
    wire logic signed [31:0] power_w;
    wire logic signed [31:0] inlet_w;
    wire logic signed [31:0] outlet_w;
    wire logic signed [31:0] delta_w;
    wire logic signed [31:0] time_w;
    wire logic signed [31:0] hc_w;
    assign flow_w = {16'h0000, meas.flow};
    assign power_w = {16'h0000, meas.power};
    assign inlet_w = {{16{meas.inlet_temp[15]}}, meas.inlet_temp};
    assign outlet_w = {{16{meas.outlet_temp[15]}}, meas.outlet_temp};
    assign delta_w = inlet_w - outlet_w;
    assign time_w = {21'h000000, meas.time_min};
    assign hc_w = {{16{hc_thresh_q[15]}}, hc_thresh_q};

    // Value for the banded tariffs.
    wire logic signed [31:0] band_value;
    wire logic [1:0] band;
    assign band_value = is_flow ? flow_w :
                        is_delta ? delta_w :
                        is_inlet ? inlet_w : outlet_w;

    trs_band_classify u_band (
        .value(band_value),
        .lim_2(lim_2),
        .lim_3(lim_3),
        .lim_4(lim_4),
        .descending(is_delta),
        .band(band)
    );

    // Banded tariffs: flow, difference, inlet and outlet.
    wire logic [2:0] hit_banded;
    assign hit_banded[0] = is_banded && (band == trs_pkg::BAND_T2);
    assign hit_banded[1] = is_banded && (band == trs_pkg::BAND_T3);
    assign hit_banded[2] = is_banded && (band == trs_pkg::BAND_T4);

    // Time windows; the last window wraps over midnight back to limit 2.
    // With misordered limits a window may overlap; priority keeps one hit.
    wire logic t_in_2;
    wire logic t_in_3;
    wire logic t_in_4;
    wire logic [2:0] hit_time;
    assign t_in_2 = (time_w >= lim_2) && (time_w < lim_3);
    assign t_in_3 = (time_w >= lim_3) && (time_w < lim_4);
    assign t_in_4 = (time_w >= lim_4) || (time_w < lim_2);
    assign hit_time[0] = is_time && t_in_2;
    assign hit_time[1] = is_time && t_in_3 && !t_in_2;
    assign hit_time[2] = is_time && t_in_4 && !t_in_2 && !t_in_3;

    // Heat/cooling volume split; equal temperatures count nowhere extra.
    wire logic vol_active;
    wire logic [2:0] hit_vol;
    assign vol_active = is_volume && hc_meter;
    assign hit_vol[0] = vol_active && (inlet_w > outlet_w) && (inlet_w >= hc_w);
    assign hit_vol[1] = vol_active && (outlet_w > inlet_w) && (inlet_w <= hc_w);
    assign hit_vol[2] = 1'b0;

    // Combined power and flow; limit 4 plays no part here.
    wire logic [2:0] hit_pq;
    assign hit_pq[0] = is_pq && (power_w > lim_2);
    assign hit_pq[1] = is_pq && (flow_w > lim_3);
    assign hit_pq[2] = 1'b0;

    // Unlisted codes, the no-tariff code among them, select nothing.
    wire logic [2:0] hit_sel;
    wire logic [15:0] inc_sel;
    assign hit_sel = hit_banded | hit_time | hit_vol | hit_pq;
    assign inc_sel = is_volume ? volume_inc : energy_inc;

    // Limit order check for the configured tariff.
    wire logic order_up;
    wire logic order_down;
    wire logic limits_misordered;
    assign order_up = (lim_3 > lim_2) && (lim_4 > lim_3);
    assign order_down = (lim_3 < lim_2) && (lim_4 < lim_3);
    assign limits_misordered = is_delta ? !order_down :
                               (is_flow || is_inlet || is_outlet || is_time) ? !order_up :
                               1'b0;

    // Auto detect replaces the low code digits only while the code is of auto form.
    wire logic auto_apply;
    assign auto_apply = auto_detect_valid &&
                        (config_q.flow_sensor_code[11:8] == trs_pkg::AUTO_DETECT_DIGIT);

    // Configuration register; a software write wins over auto detect.
    always_ff @(posedge clk) begin
        if (srst) begin
            config_q <= trs_pkg::RESET_CONFIG;
        end else if (wr_config) begin
            config_q <= {8'h00, reg_wdata[23:0]};
        end else if (auto_apply) begin
            config_q.flow_sensor_code[7:0] <= auto_detect_code[7:0];
        end
    end

    // Limits; auto detect never touches them, so their stored values stay.
    always_ff @(posedge clk) begin
        if (srst) begin
            limit_2_q <= trs_pkg::RESET_LIMIT;
            limit_3_q <= trs_pkg::RESET_LIMIT;
            limit_4_q <= trs_pkg::RESET_LIMIT;
            hc_thresh_q <= trs_pkg::RESET_LIMIT;
        end else begin
            if (wr_lim2) limit_2_q <= reg_wdata[15:0];
            if (wr_lim3) limit_3_q <= reg_wdata[15:0];
            if (wr_lim4) limit_4_q <= reg_wdata[15:0];
            if (wr_hc) hc_thresh_q <= reg_wdata[15:0];
        end
    end

    // Update stage: the condition is captured once per accumulation update.
    always_ff @(posedge clk) begin
        if (srst) begin
            upd_q <= 1'b0;
            hit_q <= 3'h0;
            inc_q <= 16'h0000;
            energy_q <= 16'h0000;
            volume_q <= 16'h0000;
            band_q <= trs_pkg::BAND_MAIN;
        end else begin
            upd_q <= acc_update;
            if (acc_update) begin
                hit_q <= hit_sel;
                inc_q <= inc_sel;
                energy_q <= energy_inc;
                volume_q <= volume_inc;
                band_q <= band;
            end
        end
    end

    // A clear request is held one cycle so it meets the add stage.
    always_ff @(posedge clk) begin
        if (srst) begin
            clear_q <= 1'b0;
        end else begin
            clear_q <= wr_clear;
        end
    end

    // Accumulator next values; an add in the clearing cycle is not lost.
    wire logic [31:0] main_base;
    wire logic [31:0] vol_base;
    wire logic [31:0] t2_base;
    wire logic [31:0] t3_base;
    wire logic [31:0] t4_base;
    assign main_base = clear_q ? trs_pkg::RESET_ACC : main_energy_q;
    assign vol_base = clear_q ? trs_pkg::RESET_ACC : total_vol_q;
    assign t2_base = clear_q ? trs_pkg::RESET_ACC : tariff_acc_2_q;
    assign t3_base = clear_q ? trs_pkg::RESET_ACC : tariff_acc_3_q;
    assign t4_base = clear_q ? trs_pkg::RESET_ACC : tariff_acc_4_q;

    wire logic [31:0] inc_w;
    wire logic [31:0] energy_w;
    wire logic [31:0] volume_w;
    assign inc_w = upd_q ? {16'h0000, inc_q} : 32'h0000_0000;
    assign energy_w = upd_q ? {16'h0000, energy_q} : 32'h0000_0000;
    assign volume_w = upd_q ? {16'h0000, volume_q} : 32'h0000_0000;

    // Main accumulators count on every update whatever the tariff.
    always_ff @(posedge clk) begin
        if (srst) begin
            main_energy_q <= trs_pkg::RESET_ACC;
            total_vol_q <= trs_pkg::RESET_ACC;
        end else begin
            main_energy_q <= main_base + energy_w;
            total_vol_q <= vol_base + volume_w;
        end
    end

    // Tariff accumulators count only when selected in the captured update.
    always_ff @(posedge clk) begin
        if (srst) begin
            tariff_acc_2_q <= trs_pkg::RESET_ACC;
            tariff_acc_3_q <= trs_pkg::RESET_ACC;
            tariff_acc_4_q <= trs_pkg::RESET_ACC;
        end else begin
            tariff_acc_2_q <= t2_base + (hit_q[0] ? inc_w : 32'h0000_0000);
            tariff_acc_3_q <= t3_base + (hit_q[1] ? inc_w : 32'h0000_0000);
            tariff_acc_4_q <= t4_base + (hit_q[2] ? inc_w : 32'h0000_0000);
        end
    end

    // Read mux; unmapped indices read as zero.
    wire logic [31:0] status_w;
    wire logic [31:0] rd_mux;
    assign status_w = {26'h0000000, limits_misordered, band_q, hit_q};
    assign rd_mux = (reg_addr == trs_pkg::REG_CONFIG) ? config_q :
                    (reg_addr == trs_pkg::REG_LIMIT_2) ? {16'h0000, limit_2_q} :
                    (reg_addr == trs_pkg::REG_LIMIT_3) ? {16'h0000, limit_3_q} :
                    (reg_addr == trs_pkg::REG_LIMIT_4) ? {16'h0000, limit_4_q} :
                    (reg_addr == trs_pkg::REG_HC_THRESH) ? {16'h0000, hc_thresh_q} :
                    (reg_addr == trs_pkg::REG_STATUS) ? status_w :
                    (reg_addr == trs_pkg::REG_MAIN_ENERGY) ? main_energy_q :
                    (reg_addr == trs_pkg::REG_TOTAL_VOL) ? total_vol_q :
                    (reg_addr == trs_pkg::REG_TARIFF_2) ? tariff_acc_2_q :
                    (reg_addr == trs_pkg::REG_TARIFF_3) ? tariff_acc_3_q :
                    (reg_addr == trs_pkg::REG_TARIFF_4) ? tariff_acc_4_q :
                    32'h0000_0000;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;
    assign upd_strobe = upd_q;
    assign tariff_hit = hit_q;
    assign tariff_inc = inc_q;

endmodule // trs_tariff_selector
`default_nettype wire

/* File: sim/trs_tariff_selector_assertions.sv */
// Purpose: Port-level checks for the tariff register selector.
// Assumes: The tariff type code only changes through config writes.
// Notes: A shadow of the code lets the checks depend on the active tariff.
`timescale 1ns/1ps
`default_nettype none
module trs_tariff_selector_assertions (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic acc_update,
    input wire logic [15:0] energy_inc,
    input wire logic [15:0] volume_inc,
    input wire trs_pkg::trs_meas_type meas,
    input wire logic upd_strobe,
    input wire logic [2:0] tariff_hit,
    input wire logic [15:0] tariff_inc
);
    logic [7:0] tt_q;
    logic [7:0] tt_d;
    logic is_vol;
    // Shadow code follows writes at the same edge as the design's config word.
    assign tt_d = (reg_wr && reg_addr == trs_pkg::REG_CONFIG) ? reg_wdata[7:0] : tt_q;
    assign is_vol = (tt_q == trs_pkg::TT_VOLUME);
    always_ff @(posedge clk) begin
        tt_q <= srst ? 8'h00 : tt_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_strobe; acc_update |=> upd_strobe; endproperty
    a_strobe: assert property (p_strobe) else $error("update strobe missing");
    property p_quiet; !acc_update |=> !upd_strobe; endproperty
    a_quiet: assert property (p_quiet) else $error("stray update strobe");
    property p_hold; !upd_strobe |-> $stable(tariff_hit) && $stable(tariff_inc); endproperty
    a_hold: assert property (p_hold) else $error("hits changed without update");
    property p_none; acc_update && tt_q == trs_pkg::TT_NONE |=> tariff_hit == 3'h0; endproperty
    a_none: assert property (p_none) else $error("hit with no tariff");
    property p_one; acc_update && tt_q != trs_pkg::TT_PQ |=> $onehot0(tariff_hit); endproperty
    a_one: assert property (p_one) else $error("more than one tariff hit");
    property p_vol;
        acc_update && is_vol |=> tariff_inc == $past(volume_inc) && !tariff_hit[2];
    endproperty
    a_vol: assert property (p_vol) else $error("volume tariff routing wrong");
    property p_veq;
        acc_update && is_vol && meas.inlet_temp == meas.outlet_temp |=> tariff_hit == 3'h0;
    endproperty
    a_veq: assert property (p_veq) else $error("equal temps counted");
    property p_pq; acc_update && tt_q == trs_pkg::TT_PQ |=> !tariff_hit[2]; endproperty
    a_pq: assert property (p_pq) else $error("fourth acc used in PQ");
    property p_einc; acc_update && !is_vol |=> tariff_inc == $past(energy_inc); endproperty
    a_einc: assert property (p_einc) else $error("energy increment wrong");
    property p_rd0; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rd0: assert property (p_rd0) else $error("read data without read");
    c_both: cover property (upd_strobe && tariff_hit == 3'h3);
    c_four: cover property (upd_strobe && tariff_hit == 3'h4);
    c_vol: cover property (acc_update && is_vol);
endmodule // trs_tariff_selector_assertions
`default_nettype wire

/* File: sim/trs_tariff_selector_tb.sv */
// Purpose: Self-checking bench for the tariff register selector.
// Assumes: Limits are programmed in the order each tariff expects.
// Notes: Flow limits use resolution class 0 unless auto detect changes it.
`timescale 1ns/1ps
`default_nettype none
module trs_tariff_selector_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic acc_update = 1'b0;
    logic [15:0] energy_inc = 16'h0005;
    logic [15:0] volume_inc = 16'h0007;
    trs_pkg::trs_meas_type meas = '0;
    logic auto_detect_valid = 1'b0;
    logic [11:0] auto_detect_code = 12'h000;
    logic upd_strobe;
    logic [2:0] tariff_hit;
    logic [15:0] tariff_inc;
    int err_total = 0;
    int total_checks = 0;
    int v;
    int o;
    logic [2:0] e;
    logic [7:0] tc[5] = '{trs_pkg::TT_FLOW, trs_pkg::TT_INLET, trs_pkg::TT_OUTLET,
        trs_pkg::TT_DELTA, trs_pkg::TT_TIME};
    int tl[5][3] = '{'{100, 200, 300}, '{100, 200, 300}, '{100, 200, 300}, '{50, 30, 10},
        '{480, 960, 1380}};
    int tv[5][6] = '{'{100, 101, 200, 201, 300, 301}, '{100, 101, 200, 201, 300, 301},
        '{100, 101, 200, 201, 300, 301}, '{70, 69, 50, 49, 30, 29},
        '{479, 480, 959, 960, 1379, 1380}};
    logic [2:0] ah[6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4};
    int vi[7] = '{50, 35, 30, 45, 40, 40, 40};
    int vo[7] = '{30, 30, 50, 50, 40, 30, 50};
    logic [2:0] ve[7] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h0, 3'h1, 3'h2};

    // Free-running system clock.
    always #25 clk = ~clk;

    trs_tariff_selector DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .acc_update(acc_update), .energy_inc(energy_inc), .volume_inc(volume_inc),
        .meas(meas), .auto_detect_valid(auto_detect_valid),
        .auto_detect_code(auto_detect_code), .upd_strobe(upd_strobe),
        .tariff_hit(tariff_hit), .tariff_inc(tariff_inc));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so sample it there.
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task automatic cfg(input logic [31:0] c, input int l2, input int l3, input int l4);
        wr(trs_pkg::REG_CONFIG, c);
        wr(trs_pkg::REG_LIMIT_2, l2);
        wr(trs_pkg::REG_LIMIT_3, l3);
        wr(trs_pkg::REG_LIMIT_4, l4);
    endtask

    task automatic upd(input int f, input int p, input int i, input int o, input int t,
            input logic [2:0] e);
        @(posedge clk);
        meas <= '{f[15:0], p[15:0], i[15:0], o[15:0], t[10:0]};
        acc_update <= 1'b1;
        @(posedge clk);
        acc_update <= 1'b0;
        #1 chk({29'h0, tariff_hit}, {29'h0, e});
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset, then each tariff through its band edges.
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd(trs_pkg::REG_LIMIT_2, 32'h0);
        rd(4'hf, 32'h0);
        cfg(32'h0000_0200, 100, 200, 300);
        upd(500, 500, 500, 500, 500, 3'h0);
        foreach (tc[k]) begin
            cfg({24'h000002, tc[k]}, tl[k][0], tl[k][1], tl[k][2]);
            foreach (ah[j]) begin
                v = tv[k][j];
                o = (tc[k] == trs_pkg::TT_OUTLET) ? v : ((tc[k] == trs_pkg::TT_DELTA) ? 20 : 0);
                e = (k == 4 && j == 0) ? 3'h4 : ah[j];
                upd(v, 0, v, o, v, e);
            end
        end
        upd(0, 0, 15, 20, 0, 3'h4);
        cfg(32'h0080_0212, 100, 200, 300);
        @(posedge clk);
        auto_detect_code <= 12'h010;
        auto_detect_valid <= 1'b1;
        @(posedge clk);
        auto_detect_valid <= 1'b0;
        rd(trs_pkg::REG_CONFIG, 32'h0081_0212);
        rd(trs_pkg::REG_LIMIT_2, 32'h0000_0064);
        upd(1000, 0, 0, 0, 0, 3'h0);
        upd(1001, 0, 0, 0, 0, 3'h1);
        cfg(32'h0000_0320, 0, 0, 0);
        wr(trs_pkg::REG_HC_THRESH, 32'h0000_0028);
        foreach (vi[j]) upd(0, 0, vi[j], vo[j], 0, ve[j]);
        wr(trs_pkg::REG_CONFIG, 32'h0000_0620);
        upd(0, 0, 50, 30, 0, 3'h1);
        wr(trs_pkg::REG_CONFIG, 32'h0000_0220);
        upd(0, 0, 50, 30, 0, 3'h0);
        cfg(32'h0000_0221, 100, 200, 300);
        wr(trs_pkg::REG_CONTROL, 32'h0000_0001);
        for (int j = 0; j < 4; j++) upd(200 + j / 2, 100 + j % 2, 0, 0, 0, 3'(j));
        rd(trs_pkg::REG_MAIN_ENERGY, 32'h0000_0014);
        rd(trs_pkg::REG_TOTAL_VOL, 32'h0000_001c);
        rd(trs_pkg::REG_TARIFF_2, 32'h0000_000a);
        rd(trs_pkg::REG_TARIFF_3, 32'h0000_000a);
        rd(trs_pkg::REG_TARIFF_4, 32'h0000_0000);
        rd(trs_pkg::REG_CONTROL, 32'h0);
        // Status keeps the last hits; the order flag follows the live code and limits.
        wr(trs_pkg::REG_CONFIG, 32'h0000_0212);
        rd(trs_pkg::REG_STATUS, 32'h0000_0003);
        wr(trs_pkg::REG_CONFIG, 32'h0000_0213);
        rd(trs_pkg::REG_STATUS, 32'h0000_0023);
        results();
    end

    // Watchdog: the sequence needs well under a tenth of this span.
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule // trs_tariff_selector_tb

bind trs_tariff_selector trs_tariff_selector_assertions u_chk (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .acc_update(acc_update), .energy_inc(energy_inc),
    .volume_inc(volume_inc), .meas(meas), .upd_strobe(upd_strobe),
    .tariff_hit(tariff_hit), .tariff_inc(tariff_inc));
`default_nettype wire
